// [hdl/mtcap_csrs.sv]
// What this block does
// RL1: Scratch resets null, stores every field
// RL2: Return-address register full capability, resets null
// RL3: Writes force address bit 0 low
// RL4: Bit 1 reads low under 32-bit alignment
// RL5: Unrepresentable legalised address clears the tag
// RL6: Sealed capability keeps tag if unchanged
// RL7: Only machine traps load it, with pcc
// RL8: Executable vector, invalid addresses need not fit
// RL9: Return unseals it into pcc
// RL10: Cause register holds capability fault code
// RL11: Standard synchronous exception code encoding
// RL12: Breakpoint, then fetch capability fault first
// RL13: Data capability fault below ecall, above translation
// RL14: Misalignment optionally early, otherwise lowest
// RL15: Delegation bit 28 writable, sends to supervisor
// RL16: Machine capability fault writes type and cause
// RL17: Type bits 19:16, cause bits 3:0
// RL18: Trap value read-only zero when unused
// RL19: Type codes fetch, data, jump
// RL20: Cause codes tag, seal, permission
`timescale 1ns/1ns
`default_nettype none
module mtcap_csrs
    import mtcap_pkg::*;
#(
    parameter bit ALIGN_SWITCHABLE = 1'b1,
    parameter bit MISAL_HIGH       = 1'b0,
    parameter bit TVAL_RO          = 1'b0
)
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // CSR access
    input  wire mtcap_csr_req_t csr_req,
    output mtcap_cap_t          csr_rdata,
    output logic                csr_rvalid,
    // Trap entry
    input  wire mtcap_trap_t    trap,
    input  wire logic [1:0]     cur_priv,
    output logic                trap_to_m,
    output logic                trap_to_s,
    output logic [5:0]          trap_code,
    // Machine return
    input  wire logic           machine_return_instruction,
    output mtcap_cap_t          ret_pcc,
    output logic                ret_valid,
    // Alignment mode
    input  wire logic           instruction_alignment_setting
);

    // ==========================================================
    // State
    mtcap_cap_t  scratch;
    mtcap_cap_t  epc;
    logic [63:0] mcause;
    logic [63:0] medeleg;
    logic [63:0] trap_val;

    mtcap_cap_t  wr_src;
    mtcap_cap_t  wr_legal;
    mtcap_cap_t  rd_legal;
    logic        prio_hit;
    logic [5:0]  prio_code;
    logic        deleg;
    logic        take_m;
    logic        take_s;
    logic        csr_wr;
    logic        align32;
    logic [63:0] next_trap_val;

    // ==========================================================
    // Legalisers and priority
    // Trap entry shares the write legaliser so pcc gets bit 0 cleared too
    assign wr_src  = take_m ? trap.pcc : csr_req.wdata;
    assign align32 = ALIGN_SWITCHABLE && instruction_alignment_setting;

    mtcap_legalise u_wr_legal (
        .cap_in     (wr_src),
        .clear_bit1 (1'b0),
        .cap_out    (wr_legal)
    );

    // RL4: read path clears bit 1
    mtcap_legalise u_rd_legal (
        .cap_in     (epc),
        .clear_bit1 (align32),
        .cap_out    (rd_legal)
    );

    mtcap_prio #(
        .MISAL_HIGH (MISAL_HIGH)
    ) u_prio (
        .src  (trap.src),
        .hit  (prio_hit),
        .code (prio_code)
    );

    // ==========================================================
    // Trap routing
    // RL15: delegation by medeleg bit
    assign deleg  = medeleg[prio_code] && (cur_priv != PRIV_M);
    assign take_m = trap.valid && prio_hit && !deleg;
    assign take_s = trap.valid && prio_hit && deleg;
    assign csr_wr = csr_req.valid && csr_req.write;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trap_to_m <= 1'b0;
            trap_to_s <= 1'b0;
            trap_code <= 6'h00;
        end else begin
            trap_to_m <= take_m;
            trap_to_s <= take_s;
            trap_code <= prio_hit ? prio_code : 6'h00;
        end
    end

    // ==========================================================
    // Scratch capability
    always_ff @(posedge clk or negedge rstn) begin
        // RL1: null at reset, no metadata legalising
        if (!rstn) begin
            scratch <= NULL_CAP;
        end else if (csr_wr && csr_req.addr == CSR_MSCRATCHC) begin
            scratch <= csr_req.wdata;
        end
    end

    // ==========================================================
    // Exception return-address capability
    always_ff @(posedge clk or negedge rstn) begin
        // RL2: null at reset
        if (!rstn) begin
            epc <= NULL_CAP;
        // RL7: trap wins over a software write
        end else if (take_m) begin
            epc <= wr_legal;
        // RL3: bit 0 cleared on every write
        end else if (csr_wr && csr_req.addr == CSR_MEPCC) begin
            epc <= wr_legal;
        end
    end

    // ==========================================================
    // Cause and delegation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mcause <= MCAUSE_RESET;
        // RL10: six code bits reach 28
        end else if (take_m) begin
            mcause <= {58'h0, prio_code};
        end else if (csr_wr && csr_req.addr == CSR_MCAUSE) begin
            mcause <= csr_req.wdata.addr;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            medeleg <= MEDELEG_RESET;
        // RL15: bit 28 is writable
        end else if (csr_wr && csr_req.addr == CSR_MEDELEG) begin
            medeleg <= csr_req.wdata.addr & MEDELEG_MASK;
        end
    end

    // ==========================================================
    // Trap value
    always_comb begin
        next_trap_val = trap_val;
        if (take_m && prio_code == EXC_CAPF) begin
            // RL16: fault type and cause
            // RL17: fields placed, rest zero
            next_trap_val = 64'h0;
            next_trap_val[TVAL_TYPE_LSB +: 4]  = trap.ftype;
            next_trap_val[TVAL_CAUSE_LSB +: 4] = trap.fcause;
        end else if (take_m) begin
            next_trap_val = trap.tval;
        end else if (csr_wr && csr_req.addr == CSR_TVAL) begin
            next_trap_val = csr_req.wdata.addr;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trap_val <= TVAL_RESET;
        // RL18: read-only zero option
        end else if (TVAL_RO) begin
            trap_val <= TVAL_RESET;
        end else begin
            trap_val <= next_trap_val;
        end
    end

    // ==========================================================
    // Read port, one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csr_rdata  <= NULL_CAP;
            csr_rvalid <= 1'b0;
        end else begin
            csr_rvalid <= csr_req.valid && !csr_req.write;
            csr_rdata  <= NULL_CAP;
            if (csr_req.valid && !csr_req.write) begin
                case (csr_req.addr)
                    CSR_MSCRATCHC: begin
                        csr_rdata <= scratch;
                    end
                    CSR_MEPCC: begin
                        csr_rdata <= rd_legal;
                    end
                    CSR_MCAUSE: begin
                        csr_rdata.addr <= mcause;
                    end
                    CSR_MEDELEG: begin
                        csr_rdata.addr <= medeleg;
                    end
                    CSR_TVAL: begin
                        csr_rdata.addr <= trap_val;
                    end
                    default: begin
                        csr_rdata <= NULL_CAP;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Machine return
    // RL8: no widening for invalid addresses, the vector only executes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ret_pcc   <= NULL_CAP;
            ret_valid <= 1'b0;
        end else begin
            ret_valid <= machine_return_instruction;
            if (machine_return_instruction) begin
                ret_pcc <= rd_legal;
                // RL9: unseal on install
                ret_pcc.otype <= 4'h0;
            end
        end
    end

    // ==========================================================
    // Checks
    epc_bit0_a: assert property ( // RL3
        @(posedge clk) disable iff (!rstn)
        epc.addr[0] == 1'b0)
        else $error("return address bit 0 set");

    scratch_keep_a: assert property ( // RL1
        @(posedge clk) disable iff (!rstn)
        csr_wr && csr_req.addr == CSR_MSCRATCHC
        |=> scratch == $past(csr_req.wdata))
        else $error("scratch lost written fields");

    epc_trap_a: assert property ( // RL7
        @(posedge clk) disable iff (!rstn)
        take_m |=> epc.addr == {$past(trap.pcc.addr[63:1]), 1'b0})
        else $error("trap did not load pcc");

    epc_hold_a: assert property ( // RL7
        @(posedge clk) disable iff (!rstn)
        !take_m && !(csr_wr && csr_req.addr == CSR_MEPCC) |=> $stable(epc))
        else $error("return address changed unprompted");

    epc_bit1_a: assert property ( // RL4
        @(posedge clk) disable iff (!rstn)
        csr_req.valid && !csr_req.write && csr_req.addr == CSR_MEPCC && align32
        |=> csr_rvalid && csr_rdata.addr[1] == 1'b0)
        else $error("bit 1 visible under 32-bit alignment");

    ret_unseal_a: assert property ( // RL9
        @(posedge clk) disable iff (!rstn)
        machine_return_instruction
        |=> ret_valid && ret_pcc.otype == 4'h0
            && ret_pcc.addr == $past(rd_legal.addr))
        else $error("return capability not unsealed");

    tval_fields_a: assert property ( // RL17
        @(posedge clk) disable iff (!rstn)
        take_m && prio_code == EXC_CAPF && !TVAL_RO
        |=> trap_val[19:16] == $past(trap.ftype) && trap_val[3:0] == $past(trap.fcause)
            && trap_val[63:20] == 44'h0 && trap_val[15:4] == 12'h0)
        else $error("trap value layout wrong");

    cause_28_a: assert property ( // RL10
        @(posedge clk) disable iff (!rstn)
        take_m && prio_code == EXC_CAPF |=> mcause == 64'h1c)
        else $error("cause did not record 28");

    deleg_cap_a: assert property ( // RL15
        @(posedge clk) disable iff (!rstn)
        trap.valid && prio_hit && prio_code == EXC_CAPF && medeleg[28]
        && cur_priv != PRIV_M && !csr_wr
        |=> trap_to_s && !trap_to_m && $stable(epc) && $stable(mcause))
        else $error("delegated fault taken in machine mode");

    brk_first_a: assert property ( // RL12
        @(posedge clk) disable iff (!rstn)
        trap.valid && trap.src.ibrk |-> prio_code == EXC_BRK)
        else $error("breakpoint not highest");

    fetch_cap_a: assert property ( // RL12
        @(posedge clk) disable iff (!rstn)
        trap.valid && !trap.src.ibrk && trap.src.cap_fetch |-> prio_code == EXC_CAPF)
        else $error("fetch capability fault outranked");

    data_cap_a: assert property ( // RL13
        @(posedge clk) disable iff (!rstn)
        trap.valid && trap.src.cap_data && (trap.src.lpf || trap.src.sacc)
        && !trap.src.illegal && !trap.src.ecall_u && !trap.src.dbrk
        && !trap.src.ibrk && !trap.src.cap_fetch && !trap.src.ipf
        && !trap.src.iacc_xlat && !trap.src.iacc_phys && !trap.src.imisal
        && !trap.src.ecall_s && !trap.src.ecall_m && !trap.src.ebreak
        |-> prio_code == EXC_CAPF)
        else $error("data capability fault misranked");

    misal_low_a: assert property ( // RL14
        @(posedge clk) disable iff (!rstn)
        !MISAL_HIGH && trap.valid && trap.src.lmisal && trap.src.lpf
        && !trap.src.cap_data && !trap.src.illegal
        |-> prio_code != EXC_LMISAL)
        else $error("misalignment not lowest");

    tval_ro_a: assert property ( // RL18
        @(posedge clk) disable iff (!rstn)
        TVAL_RO |-> trap_val == 64'h0)
        else $error("trap value not read-only zero");

    tval_other_a: assert property ( // RL16
        @(posedge clk) disable iff (!rstn)
        take_m && prio_code != EXC_CAPF && !TVAL_RO |=> trap_val == $past(trap.tval))
        else $error("non-capability trap value wrong");

    epc_rep_a: assert property ( // RL5
        @(posedge clk) disable iff (!rstn)
        epc.tag |-> epc.addr >= epc.base && epc.addr <= epc.top)
        else $error("tagged return address outside region");

endmodule
`default_nettype wire

// [hdl/mtcap_legalise.sv]
`timescale 1ns/1ns
`default_nettype none
module mtcap_legalise
    import mtcap_pkg::*;
(
    // Capability in and out
    input  wire mtcap_cap_t cap_in,
    input  wire logic       clear_bit1,
    output mtcap_cap_t      cap_out
);

    logic [63:0] legal_addr;
    logic        in_rep;
    logic        changed;

    always_comb begin
        legal_addr = {cap_in.addr[63:2], cap_in.addr[1] & ~clear_bit1, 1'b0};
        in_rep     = (legal_addr >= cap_in.base) && (legal_addr <= cap_in.top);
        changed    = legal_addr != cap_in.addr;
        cap_out    = cap_in;
        cap_out.addr = legal_addr;
        // RL5: unrepresentable drops tag
        // RL6: sealed keeps tag only if unchanged
        cap_out.tag = cap_in.tag && in_rep && !((cap_in.otype != 4'h0) && changed);
    end

endmodule
`default_nettype wire

// [hdl/mtcap_pkg.sv]
`default_nettype none
package mtcap_pkg;

    // ==========================================================
    // Widths and CSR numbers
    localparam int XLEN = 64;
    localparam logic [11:0] CSR_MSCRATCHC = 12'h760;
    localparam logic [11:0] CSR_MEPCC     = 12'h761;
    localparam logic [11:0] CSR_MEDELEG   = 12'h302;
    localparam logic [11:0] CSR_MCAUSE    = 12'h342;
    localparam logic [11:0] CSR_TVAL      = 12'h343;

    // ==========================================================
    // Synchronous exception codes
    // RL11: standard exception codes
    localparam logic [5:0] EXC_IMISAL  = 6'h00;
    localparam logic [5:0] EXC_IACC    = 6'h01;
    localparam logic [5:0] EXC_ILLEGAL = 6'h02;
    localparam logic [5:0] EXC_BRK     = 6'h03;
    localparam logic [5:0] EXC_LMISAL  = 6'h04;
    localparam logic [5:0] EXC_LACC    = 6'h05;
    localparam logic [5:0] EXC_SMISAL  = 6'h06;
    localparam logic [5:0] EXC_SACC    = 6'h07;
    localparam logic [5:0] EXC_ECALL_U = 6'h08;
    localparam logic [5:0] EXC_ECALL_S = 6'h09;
    localparam logic [5:0] EXC_ECALL_M = 6'h0b;
    localparam logic [5:0] EXC_IPF     = 6'h0c;
    localparam logic [5:0] EXC_LPF     = 6'h0d;
    localparam logic [5:0] EXC_SPF     = 6'h0f;
    localparam logic [5:0] EXC_CAPF    = 6'h1c;

    // ==========================================================
    // Reset values, masks, trap value layout
    localparam logic [63:0] MEDELEG_MASK  = 64'h0000_0000_1000_bbff;
    localparam logic [63:0] MEDELEG_RESET = 64'h0;
    localparam logic [63:0] MCAUSE_RESET  = 64'h0;
    localparam logic [63:0] TVAL_RESET    = 64'h0;
    localparam int TVAL_TYPE_LSB  = 16;
    localparam int TVAL_CAUSE_LSB = 0;
    localparam logic [1:0] PRIV_M = 2'h3;

    // RL19: fault type codes
    typedef enum logic [3:0] {
        MTCAP_FT_FETCH = 4'h0,
        MTCAP_FT_DATA  = 4'h1,
        MTCAP_FT_JUMP  = 4'h2
    } mtcap_ftype_t;

    // RL20: fault cause codes
    typedef enum logic [3:0] {
        MTCAP_FC_TAG    = 4'h0,
        MTCAP_FC_SEAL   = 4'h1,
        MTCAP_FC_PERM   = 4'h2,
        MTCAP_FC_LENGTH = 4'h3
    } mtcap_fcause_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        tag;
        logic [3:0]  otype;
        logic [11:0] perms;
        logic [63:0] base;
        logic [63:0] top;
        logic [63:0] addr;
    } mtcap_cap_t;

    localparam mtcap_cap_t NULL_CAP = '0;

    typedef struct packed {
        logic ibrk;
        logic cap_fetch;
        logic ipf;
        logic iacc_xlat;
        logic iacc_phys;
        logic illegal;
        logic imisal;
        logic ecall_u;
        logic ecall_s;
        logic ecall_m;
        logic ebreak;
        logic dbrk;
        logic cap_data;
        logic lmisal;
        logic smisal;
        logic lpf;
        logic spf;
        logic lacc;
        logic sacc;
    } mtcap_src_t;

    typedef struct packed {
        logic          valid;
        logic          write;
        logic [11:0]   addr;
        mtcap_cap_t    wdata;
    } mtcap_csr_req_t;

    typedef struct packed {
        logic          valid;
        mtcap_src_t    src;
        mtcap_cap_t    pcc;
        mtcap_ftype_t  ftype;
        mtcap_fcause_t fcause;
        logic [63:0]   tval;
    } mtcap_trap_t;

endpackage
`default_nettype wire

// [hdl/mtcap_prio.sv]
`timescale 1ns/1ns
`default_nettype none
module mtcap_prio
    import mtcap_pkg::*;
#(
    parameter bit MISAL_HIGH = 1'b0
)
(
    // Pending sources
    input  wire mtcap_src_t src,
    // Winner
    output logic            hit,
    output logic [5:0]      code
);

    always_comb begin
        hit  = 1'b1;
        code = EXC_BRK;
        // RL12: breakpoint, then early capability fault
        if (src.ibrk) begin
            code = EXC_BRK;
        end else if (src.cap_fetch) begin
            code = EXC_CAPF;
        end else if (src.ipf) begin
            code = EXC_IPF;
        end else if (src.iacc_xlat || src.iacc_phys) begin
            code = EXC_IACC;
        end else if (src.illegal) begin
            code = EXC_ILLEGAL;
        end else if (src.imisal) begin
            code = EXC_IMISAL;
        end else if (src.ecall_u) begin
            code = EXC_ECALL_U;
        end else if (src.ecall_s) begin
            code = EXC_ECALL_S;
        end else if (src.ecall_m) begin
            code = EXC_ECALL_M;
        end else if (src.ebreak || src.dbrk) begin
            code = EXC_BRK;
        // RL13: data capability fault above data faults
        end else if (src.cap_data) begin
            code = EXC_CAPF;
        // RL14: optional early misalignment
        end else if (MISAL_HIGH && src.lmisal) begin
            code = EXC_LMISAL;
        end else if (MISAL_HIGH && src.smisal) begin
            code = EXC_SMISAL;
        end else if (src.lpf) begin
            code = EXC_LPF;
        end else if (src.spf) begin
            code = EXC_SPF;
        end else if (src.lacc) begin
            code = EXC_LACC;
        end else if (src.sacc) begin
            code = EXC_SACC;
        end else if (src.lmisal) begin
            code = EXC_LMISAL;
        end else if (src.smisal) begin
            code = EXC_SMISAL;
        end else begin
            hit = 1'b0;
        end
    end

endmodule
`default_nettype wire

// [verif/mtcap_pipe_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mtcap_pipe_model
    import mtcap_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Requests towards the CSR block
    output mtcap_csr_req_t csr_req,
    output mtcap_trap_t    trap,
    output logic           ret_pulse
);

    // ==========
    // Idle state
    initial begin
        csr_req    = '0;
        trap       = '0;
        ret_pulse  = 1'b0;
    end

    // ==========
    // Requests
    // Released addr, wdata and pcc show the inverse, so stale data is never mistaken for live
    task automatic csr_op(input logic wr, input logic [11:0] a, input mtcap_cap_t d);
        @(posedge clk);
        csr_req <= '{1'b1, wr, a, d};
        @(posedge clk);
        csr_req <= '{1'b0, 1'b0, ~a, mtcap_cap_t'(~d)};
        #1;
    endtask

    task automatic trap_op(input logic [18:0] s, input mtcap_cap_t p,
                           input logic [3:0] ft, input logic [3:0] fc);
        @(posedge clk);
        trap <= '{1'b1, mtcap_src_t'(s), p, mtcap_ftype_t'(ft), mtcap_fcause_t'(fc), 64'h5a5a};
        @(posedge clk);
        trap.valid <= 1'b0;
        trap.src   <= '0;
        trap.pcc   <= mtcap_cap_t'(~p);
        #1;
    endtask

    task automatic ret_op();
        @(posedge clk);
        ret_pulse <= 1'b1;
        @(posedge clk);
        ret_pulse <= 1'b0;
        #1;
    endtask

endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench
    import mtcap_pkg::*;
;
    logic           clk;
    logic           rstn;
    logic [1:0]     cur_priv;
    logic           align32;
    mtcap_csr_req_t csr_req;
    mtcap_trap_t    trap;
    logic           ret_pulse;
    mtcap_cap_t     csr_rdata;
    mtcap_cap_t     ret_pcc;
    logic           csr_rvalid;
    logic           trap_to_m;
    logic           trap_to_s;
    logic           ret_valid;
    logic [5:0]     trap_code;
    int             fail_count;
    int             n_checks;
    int             cycles;

    mtcap_csrs #(.ALIGN_SWITCHABLE(1'b1), .MISAL_HIGH(1'b0), .TVAL_RO(1'b0)) mtcap_csrs_inst (
        .clk(clk), .rstn(rstn), .csr_req(csr_req), .csr_rdata(csr_rdata),
        .csr_rvalid(csr_rvalid), .trap(trap), .cur_priv(cur_priv), .trap_to_m(trap_to_m),
        .trap_to_s(trap_to_s), .trap_code(trap_code), .machine_return_instruction(ret_pulse),
        .ret_pcc(ret_pcc), .ret_valid(ret_valid), .instruction_alignment_setting(align32)
    );

    mtcap_pipe_model mtcap_pipe_model_inst (
        .clk(clk), .csr_req(csr_req), .trap(trap), .ret_pulse(ret_pulse)
    );

    // ==========
    // Helpers
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic mtcap_cap_t mk(input logic t, input logic [3:0] o, input logic [63:0] a);
        mk = '{t, o, 12'hfff, 64'h1000, 64'h1fff, a};
    endfunction

    function automatic mtcap_cap_t sc(input logic [63:0] v);
        sc = NULL_CAP;
        sc.addr = v;
    endfunction

    task automatic wr(input logic [11:0] a, input mtcap_cap_t d);
        mtcap_pipe_model_inst.csr_op(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input mtcap_cap_t exp);
        mtcap_pipe_model_inst.csr_op(1'b0, a, '0);
        check(csr_rvalid, 1'b1);
        check(csr_rdata, exp);
    endtask

    task automatic trp(input logic [18:0] s, input mtcap_cap_t p);
        mtcap_pipe_model_inst.trap_op(s, p, 4'h1, 4'h2);
    endtask

    task automatic set_mode(input logic [1:0] pv, input logic al);
        @(posedge clk);
        cur_priv <= pv;
        align32  <= al;
    endtask

    task automatic prio(input logic [18:0] s, input logic [5:0] c);
        trp(s, mk(1'b1, 4'h0, 64'h1300));
        check(trap_to_m, s != '0);
        check(trap_code, c);
    endtask

    // ==========
    // Scenarios
    task automatic t_reset();
        rd(CSR_MSCRATCHC, NULL_CAP);
        rd(CSR_MEPCC, NULL_CAP);
        rd(CSR_MCAUSE, NULL_CAP);
        rd(CSR_TVAL, NULL_CAP);
        rd(12'h7ff, NULL_CAP);
        $display("test reset done");
    endtask

    task automatic t_scratch();
        mtcap_cap_t c;
        // Odd, sealed and out of bounds: still stored untouched
        c = '{1'b1, 4'h5, 12'ha53, 64'h9000, 64'h10, 64'h3};
        wr(CSR_MSCRATCHC, c);
        rd(CSR_MSCRATCHC, c);
        $display("test scratch done");
    endtask

    task automatic t_epc();
        wr(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1103));
        rd(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1102));
        set_mode(PRIV_M, 1'b1);
        rd(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1100));
        set_mode(PRIV_M, 1'b0);
        wr(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1fff));
        rd(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1ffe));
        wr(CSR_MEPCC, mk(1'b1, 4'h0, 64'h2001));
        rd(CSR_MEPCC, mk(1'b0, 4'h0, 64'h2000));
        wr(CSR_MEPCC, mk(1'b1, 4'h2, 64'h1100));
        rd(CSR_MEPCC, mk(1'b1, 4'h2, 64'h1100));
        wr(CSR_MEPCC, mk(1'b1, 4'h2, 64'h1101));
        rd(CSR_MEPCC, mk(1'b0, 4'h2, 64'h1100));
        wr(CSR_MEPCC, mk(1'b1, 4'h2, 64'h1102));
        set_mode(PRIV_M, 1'b1);
        rd(CSR_MEPCC, mk(1'b0, 4'h2, 64'h1100));
        set_mode(PRIV_M, 1'b0);
        $display("test return address done");
    endtask

    task automatic t_trap();
        for (int f = 0; f < 3; f++) begin
            for (int k = 0; k < 3; k++) begin
                mtcap_pipe_model_inst.trap_op(19'h00040, mk(1'b1, 4'h0, 64'h1205), f[3:0], k[3:0]);
                check(trap_to_m, 1'b1);
                check(trap_code, 6'h1c);
                rd(CSR_TVAL, sc({44'h0, f[3:0], 12'h0, k[3:0]}));
            end
        end
        rd(CSR_MCAUSE, sc(64'h1c));
        rd(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1204));
        $display("test trap entry done");
    endtask

    task automatic t_prio();
        prio(19'h00000, 6'h00);
        prio(19'h60000, 6'h03);
        prio(19'h38000, 6'h1c);
        prio(19'h14000, 6'h0c);
        prio(19'h02040, 6'h02);
        prio(19'h00840, 6'h08);
        prio(19'h00440, 6'h09);
        prio(19'h00240, 6'h0b);
        prio(19'h000c0, 6'h03);
        prio(19'h0004a, 6'h1c);
        prio(19'h00028, 6'h0d);
        prio(19'h00011, 6'h07);
        prio(19'h00020, 6'h04);
        prio(19'h00010, 6'h06);
        prio(19'h01000, 6'h00);
        prio(19'h04000, 6'h01);
        prio(19'h00002, 6'h05);
        prio(19'h00004, 6'h0f);
        prio(19'h00100, 6'h03);
        rd(CSR_TVAL, sc(64'h5a5a));
        wr(CSR_TVAL, sc(64'h1234));
        rd(CSR_TVAL, sc(64'h1234));
        $display("test priority done");
    endtask

    task automatic t_deleg();
        wr(CSR_MEDELEG, sc('1));
        rd(CSR_MEDELEG, sc(64'h1000_bbff));
        wr(CSR_MCAUSE, sc(64'h5));
        set_mode(2'h0, 1'b0);
        trp(19'h00040, mk(1'b1, 4'h0, 64'h1400));
        check(trap_to_s, 1'b1);
        check(trap_to_m, 1'b0);
        rd(CSR_MCAUSE, sc(64'h5));
        rd(CSR_MEPCC, mk(1'b1, 4'h0, 64'h1300));
        wr(CSR_MEDELEG, sc(64'h0));
        trp(19'h00040, mk(1'b1, 4'h0, 64'h1400));
        check(trap_to_m, 1'b1);
        check(trap_to_s, 1'b0);
        set_mode(PRIV_M, 1'b0);
        $display("test delegation done");
    endtask

    task automatic t_ret();
        wr(CSR_MEPCC, mk(1'b1, 4'h3, 64'h1500));
        mtcap_pipe_model_inst.ret_op();
        check(ret_valid, 1'b1);
        check(ret_pcc, mk(1'b1, 4'h0, 64'h1500));
        rd(CSR_MEPCC, mk(1'b1, 4'h3, 64'h1500));
        check(ret_valid, 1'b0);
        // Sealed with bit 1 set under 32-bit alignment: bit 1 drops, so does the tag
        wr(CSR_MEPCC, mk(1'b1, 4'h3, 64'h1502));
        set_mode(PRIV_M, 1'b1);
        mtcap_pipe_model_inst.ret_op();
        check(ret_pcc, mk(1'b0, 4'h0, 64'h1500));
        set_mode(PRIV_M, 1'b0);
        $display("test return done");
    endtask

    // ==========
    // Run control
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Whole run needs under 200 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            $display("ERROR at %0t: timeout", $time);
            give_verdict();
        end
    end

    initial begin
        rstn       = 1'b0;
        cur_priv   = PRIV_M;
        align32    = 1'b0;
        fail_count = 0;
        n_checks   = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_scratch();
        t_epc();
        t_trap();
        t_prio();
        t_deleg();
        t_ret();
        give_verdict();
    end

endmodule
`default_nettype wire
